/* File: common/p2pfi_regs.vh */
/*
 Register offsets, field positions, reset values and timing counts of the
 second position feedback interface. Assumes a 10 MHz core clock and byte
 addresses on an 8-bit register port.
*/
`ifndef P2PFI_REGS_VH
`define P2PFI_REGS_VH

// ==========================================================
// Register offsets
`define P2PFI_DEVICE_TYPE_ADDR    8'h00
`define P2PFI_FB_SELECT_ADDR      8'h04
`define P2PFI_LINES_PER_REV_ADDR  8'h08
`define P2PFI_MARKER_CTRL_ADDR    8'h0c
`define P2PFI_ERROR_CTRL_ADDR     8'h10
`define P2PFI_BAUD_ADDR           8'h14
`define P2PFI_SERIAL_CFG_ADDR     8'h18
`define P2PFI_TURNS_BITS_ADDR     8'h1c
`define P2PFI_COMMS_BITS_ADDR     8'h20
`define P2PFI_POSITION_ADDR       8'h24
`define P2PFI_MARKER_CAPT_ADDR    8'h28
`define P2PFI_IRQ_STATUS_ADDR     8'h2c
`define P2PFI_IRQ_MASK_ADDR       8'h30
`define P2PFI_FAULT_ADDR          8'h34

// ==========================================================
// Field positions
`define P2PFI_CFG_AUTO_BIT        0
`define P2PFI_CFG_BINARY_BIT      1
`define P2PFI_IRQ_MARKER_BIT      0
`define P2PFI_IRQ_FRAME_BIT       1
`define P2PFI_IRQ_PSU_ALARM_BIT   2
`define P2PFI_IRQ_TRIP_BIT        3
`define P2PFI_MRK_ONCE_BIT        0
`define P2PFI_MRK_ZERO_BIT        1
`define P2PFI_MRK_NORESET_BIT     2
`define P2PFI_MRK_WIDTH_BIT       3
`define P2PFI_ERR_PSU_BIT         2
`define P2PFI_ERR_NOTRIP_BIT      3

// ==========================================================
// Device type codes and selector value
`define P2PFI_TYPE_AB             5'h01
`define P2PFI_TYPE_FD             5'h02
`define P2PFI_TYPE_FR             5'h03
`define P2PFI_TYPE_BIDIR          5'h04
`define P2PFI_TYPE_SSI            5'h05
`define P2PFI_TYPE_BISS           5'h06
`define P2PFI_FB_SEL_P2           2'h1

// ==========================================================
// Reset values, auto-config bit counts, bidir command and fault class
`define P2PFI_DEVICE_TYPE_RST     5'h01
`define P2PFI_LINES_PER_REV_RST   14'h0400
`define P2PFI_SERIAL_CFG_RST      2'h1
`define P2PFI_TURNS_BITS_RST      5'h0c
`define P2PFI_COMMS_BITS_RST      6'h19
`define P2PFI_AUTO_TURNS          5'h0c
`define P2PFI_AUTO_COMMS          6'h19
`define P2PFI_BIDIR_CMD           8'h07
`define P2PFI_BIDIR_CMD_BITS      4'h8
`define P2PFI_FAULT_CLASS_COMMS   4'h4

// ==========================================================
// Timing
`define P2PFI_CLK_HZ              10000000
`define P2PFI_MARKER_MIN_US       10
`define P2PFI_MARKER_MIN_CYC      7'h64 // 10 us of 10 MHz cycles
`define P2PFI_FRAME_GAP_US        30
`define P2PFI_FRAME_GAP_CYC       9'h12c // 30 us of 10 MHz cycles

`endif

/* File: verilog/p2pfi_top.v */
/*
 Second position feedback interface: incremental decoder with marker
 handling and absolute serial reader, behind a plain register port.
 Assumes encoder pins are asynchronous to clk_i and that the register
 master keeps strobes one cycle long.
*/
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "p2pfi_regs.vh"

module p2pfi_top (
   input wire clk_i,
   input wire resetn_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire enc_a_i,
   input wire enc_b_i,
   input wire enc_z_i,
   input wire sdata_i,
   output reg sdata_o,
   output reg sdata_oe_o,
   output reg sclk_o,
   output reg [31:0] fb_position_o,
   output reg fb_valid_o,
   output reg trip_o,
   output reg irq_o
);

   localparam S_GAP = 4'h1;
   localparam S_CMD = 4'h2;
   localparam S_READ = 4'h4;
   localparam S_DONE = 4'h8;

   // ==========================================================
   // Functions
   // Cycles per serial bit, rounded down so the rate never falls short
   function [6:0] bit_period;
      input [3:0] sel;
      reg [31:0] cyc;
      begin
         case (sel)
            4'h0: cyc = `P2PFI_CLK_HZ / 100000;
            4'h1: cyc = `P2PFI_CLK_HZ / 200000;
            4'h2: cyc = `P2PFI_CLK_HZ / 300000;
            4'h3: cyc = `P2PFI_CLK_HZ / 400000;
            4'h4: cyc = `P2PFI_CLK_HZ / 500000;
            4'h5: cyc = `P2PFI_CLK_HZ / 1000000;
            4'h6: cyc = `P2PFI_CLK_HZ / 1500000;
            4'h7: cyc = `P2PFI_CLK_HZ / 2000000;
            default: cyc = `P2PFI_CLK_HZ / 4000000;
         endcase
         bit_period = cyc[6:0];
      end
   endfunction

   // Gray to binary, cumulative XOR from the top bit down
   function [31:0] gray2bin;
      input [31:0] g;
      integer i;
      begin
         gray2bin = 32'h0;
         gray2bin[31] = g[31];
         for (i = 30; i >= 0; i = i - 1) begin
            gray2bin[i] = gray2bin[i + 1] ^ g[i];
         end
      end
   endfunction

   function is_serial;
      input [4:0] t;
      begin
         is_serial = (t == `P2PFI_TYPE_BIDIR) || (t == `P2PFI_TYPE_SSI) ||
                     (t == `P2PFI_TYPE_BISS);
      end
   endfunction

   // ==========================================================
   // Registers and state
   reg [4:0] dev_type_q;
   reg [1:0] fb_sel_q;
   reg [13:0] lpr_q;
   reg [3:0] mrk_ctrl_q;
   reg [3:0] err_ctrl_q;
   reg [3:0] baud_q;
   reg [1:0] ser_cfg_q;
   reg [4:0] turns_man_q;
   reg [5:0] comms_man_q;
   reg [3:0] irq_stat_q;
   reg [3:0] irq_mask_q;
   reg [3:0] fault_class_q;
   reg [31:0] capture_q;
   reg [17:0] pos_q;
   reg [13:0] rev_q;
   reg [2:0] a_sync_q;
   reg [2:0] b_sync_q;
   reg [2:0] z_sync_q;
   reg [1:0] sd_sync_q;
   reg [6:0] mrk_cnt_q;
   reg mrk_done_q;
   reg [3:0] state_q;
   reg [8:0] gap_q;
   reg [6:0] ph_q;
   reg [5:0] bits_q;
   reg [32:0] shift_q;

   wire wr_hit_irq = wr_i && (addr_i == `P2PFI_IRQ_STATUS_ADDR);
   wire [3:0] irq_clr = wr_hit_irq ? wdata_i[3:0] : 4'h0;

   // Bit counts: auto-config overrides manual values for BiSS and bidir
   wire auto_type = (dev_type_q == `P2PFI_TYPE_BISS) || (dev_type_q == `P2PFI_TYPE_BIDIR);
   wire use_auto = auto_type && ser_cfg_q[`P2PFI_CFG_AUTO_BIT];
   wire [4:0] turns_bits = use_auto ? `P2PFI_AUTO_TURNS : turns_man_q;
   wire [5:0] comms_bits = use_auto ? `P2PFI_AUTO_COMMS : comms_man_q;
   wire psu_mon = (dev_type_q == `P2PFI_TYPE_SSI) && err_ctrl_q[`P2PFI_ERR_PSU_BIT];
   wire [5:0] frame_bits = comms_bits + {5'h0, psu_mon};

   // ==========================================================
   // Register writes
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dev_type_q <= `P2PFI_DEVICE_TYPE_RST;
         fb_sel_q <= 2'h0;
         lpr_q <= `P2PFI_LINES_PER_REV_RST;
         mrk_ctrl_q <= 4'h0;
         err_ctrl_q <= 4'h0;
         baud_q <= 4'h0;
         ser_cfg_q <= `P2PFI_SERIAL_CFG_RST;
         turns_man_q <= `P2PFI_TURNS_BITS_RST;
         comms_man_q <= `P2PFI_COMMS_BITS_RST;
         irq_mask_q <= 4'h0;
      end else if (wr_i) begin
         if (addr_i == `P2PFI_DEVICE_TYPE_ADDR) begin
            dev_type_q <= wdata_i[4:0];
         end else if (addr_i == `P2PFI_FB_SELECT_ADDR) begin
            fb_sel_q <= wdata_i[1:0];
         end else if (addr_i == `P2PFI_LINES_PER_REV_ADDR) begin
            lpr_q <= wdata_i[13:0];
         end else if (addr_i == `P2PFI_MARKER_CTRL_ADDR) begin
            mrk_ctrl_q <= wdata_i[3:0];
         end else if (addr_i == `P2PFI_ERROR_CTRL_ADDR) begin
            err_ctrl_q <= wdata_i[3:0];
         end else if (addr_i == `P2PFI_BAUD_ADDR) begin
            baud_q <= (wdata_i[3:0] > 4'h8) ? 4'h8 : wdata_i[3:0];
         end else if (addr_i == `P2PFI_SERIAL_CFG_ADDR) begin
            ser_cfg_q <= wdata_i[1:0];
         end else if (addr_i == `P2PFI_TURNS_BITS_ADDR) begin
            turns_man_q <= wdata_i[4:0];
         end else if (addr_i == `P2PFI_COMMS_BITS_ADDR) begin
            comms_man_q <= (wdata_i[5:0] > 6'h20) ? 6'h20 : wdata_i[5:0];
         end else if (addr_i == `P2PFI_IRQ_MASK_ADDR) begin
            irq_mask_q <= wdata_i[3:0];
         end
      end
   end

   // ==========================================================
   // Pin synchronisers; stage 0 is read only by stage 1
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         a_sync_q <= 3'h0;
         b_sync_q <= 3'h0;
         z_sync_q <= 3'h0;
         sd_sync_q <= 2'h3;
      end else begin
         a_sync_q <= {a_sync_q[1:0], enc_a_i};
         b_sync_q <= {b_sync_q[1:0], enc_b_i};
         z_sync_q <= {z_sync_q[1:0], enc_z_i};
         sd_sync_q <= {sd_sync_q[0], sdata_i};
      end
   end

   wire a_now = a_sync_q[1];
   wire a_old = a_sync_q[2];
   wire b_now = b_sync_q[1];
   wire b_old = b_sync_q[2];
   wire sd_now = sd_sync_q[1];

   // ==========================================================
   // Incremental step decode; every line is four counts
   reg step_en;
   reg step_up;
   reg [1:0] step_sz;
   always @* begin
      step_en = 1'b0;
      step_up = 1'b0;
      step_sz = 2'h1;
      case (dev_type_q)
         `P2PFI_TYPE_AB: begin
            // Both inputs moving at once is a lost step; it is dropped
            step_en = (a_now ^ a_old) ^ (b_now ^ b_old);
            step_up = a_old ^ b_now;
         end
         `P2PFI_TYPE_FD: begin
            step_en = a_now && !a_old;
            step_up = !b_now;
            step_sz = 2'h2;
         end
         `P2PFI_TYPE_FR: begin
            step_en = (a_now && !a_old) ^ (b_now && !b_old);
            step_up = a_now && !a_old;
            step_sz = 2'h2;
         end
         default: begin
            step_en = 1'b0;
         end
      endcase
   end

   wire [17:0] rev_len = {2'b00, lpr_q, 2'b00};
   wire [17:0] pos_plus = pos_q + {16'h0, step_sz};
   wire incr_mode = (dev_type_q == `P2PFI_TYPE_AB) || (dev_type_q == `P2PFI_TYPE_FD) ||
                    (dev_type_q == `P2PFI_TYPE_FR);
   wire [31:0] combined = {rev_q, pos_q};

   // ==========================================================
   // Marker qualification
   wire z_rise = z_sync_q[1] && !z_sync_q[2];
   wire wide_ok = z_sync_q[1] && !mrk_done_q &&
                  (mrk_cnt_q == `P2PFI_MARKER_MIN_CYC - 7'h1);
   wire mrk_seen = mrk_ctrl_q[`P2PFI_MRK_WIDTH_BIT] ? wide_ok : z_rise;
   wire mrk_accept = incr_mode && mrk_seen &&
                     !(mrk_ctrl_q[`P2PFI_MRK_ONCE_BIT] && irq_stat_q[`P2PFI_IRQ_MARKER_BIT]);
   wire mrk_zero = mrk_accept && mrk_ctrl_q[`P2PFI_MRK_ZERO_BIT] &&
                   !mrk_ctrl_q[`P2PFI_MRK_NORESET_BIT];

   // Width counter restarts on every high level
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mrk_cnt_q <= 7'h0;
         mrk_done_q <= 1'b0;
      end else if (!z_sync_q[1]) begin
         mrk_cnt_q <= 7'h0;
         mrk_done_q <= 1'b0;
      end else if (wide_ok) begin
         mrk_done_q <= 1'b1;
      end else if (!mrk_done_q) begin
         mrk_cnt_q <= mrk_cnt_q + 7'h1;
      end
   end

   // ==========================================================
   // Serial frame engine
   wire [6:0] period = bit_period(baud_q);
   wire [6:0] half = {1'b0, period[6:1]};
   wire bit_end = (ph_q == period - 7'h1);
   wire sample = (ph_q == half);
   wire [7:0] cmd_bits = `P2PFI_BIDIR_CMD >> (bits_q - 6'h1);
   wire [31:0] raw = psu_mon ? shift_q[32:1] : shift_q[31:0];
   wire is_gray = (dev_type_q == `P2PFI_TYPE_SSI) && !ser_cfg_q[`P2PFI_CFG_BINARY_BIT];
   wire [31:0] word = is_gray ? gray2bin(raw) : raw;
   wire [5:0] st_bits = comms_bits - {1'b0, turns_bits};
   wire [31:0] st_mask = ~(32'hffffffff << st_bits);
   wire [31:0] abs_turns = word >> st_bits;
   wire [31:0] abs_pos = word & st_mask;
   wire frame_done = (state_q == S_DONE);
   wire alarm = frame_done && psu_mon && shift_q[0];
   wire comms_fault = (state_q == S_GAP) && (gap_q == 9'h0) &&
                      is_serial(dev_type_q) && !sd_now;
   wire trip_event = comms_fault && !err_ctrl_q[`P2PFI_ERR_NOTRIP_BIT];

   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= S_GAP;
         gap_q <= `P2PFI_FRAME_GAP_CYC;
         ph_q <= 7'h0;
         bits_q <= 6'h0;
         shift_q <= 33'h0;
         sclk_o <= 1'b1;
         sdata_o <= 1'b1;
         sdata_oe_o <= 1'b0;
      end else begin
         case (state_q)
            S_GAP: begin
               sclk_o <= 1'b1;
               sdata_oe_o <= 1'b0;
               ph_q <= 7'h0;
               if (gap_q != 9'h0) begin
                  gap_q <= gap_q - 9'h1;
               end else if (is_serial(dev_type_q) && sd_now) begin
                  // Encoder ready (data idle high): open a frame
                  shift_q <= 33'h0;
                  if (dev_type_q == `P2PFI_TYPE_BIDIR) begin
                     state_q <= S_CMD;
                     bits_q <= {2'h0, `P2PFI_BIDIR_CMD_BITS};
                  end else begin
                     state_q <= S_READ;
                     bits_q <= frame_bits;
                  end
               end else begin
                  gap_q <= `P2PFI_FRAME_GAP_CYC;
               end
            end
            S_CMD: begin
               // Command goes out MSB first, changed while the clock is low
               sclk_o <= (ph_q >= half);
               sdata_oe_o <= 1'b1;
               sdata_o <= cmd_bits[0];
               ph_q <= bit_end ? 7'h0 : ph_q + 7'h1;
               if (bit_end) begin
                  bits_q <= bits_q - 6'h1;
                  if (bits_q == 6'h1) begin
                     state_q <= S_READ;
                     bits_q <= frame_bits;
                  end
               end
            end
            S_READ: begin
               sclk_o <= (ph_q >= half);
               sdata_oe_o <= 1'b0;
               ph_q <= bit_end ? 7'h0 : ph_q + 7'h1;
               if (sample) begin
                  shift_q <= {shift_q[31:0], sd_now};
               end
               if (bit_end) begin
                  bits_q <= bits_q - 6'h1;
                  if (bits_q == 6'h1) begin
                     state_q <= S_DONE;
                  end
               end
            end
            S_DONE: begin
               sclk_o <= 1'b1;
               state_q <= S_GAP;
               gap_q <= `P2PFI_FRAME_GAP_CYC;
            end
            default: begin
               state_q <= S_GAP;
            end
         endcase
      end
   end

   // ==========================================================
   // Position, revolution count and marker capture
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pos_q <= 18'h0;
         rev_q <= 14'h0;
         capture_q <= 32'h0;
      end else begin
         if (mrk_accept) begin
            capture_q <= combined;
         end
         if (mrk_zero) begin
            pos_q <= 18'h0;
            rev_q <= 14'h0;
         end else if (frame_done) begin
            pos_q <= abs_pos[17:0];
            rev_q <= abs_turns[13:0];
         end else if (incr_mode && step_en && (rev_len != 18'h0)) begin
            if (step_up) begin
               if (pos_plus >= rev_len) begin
                  pos_q <= pos_plus - rev_len;
                  rev_q <= rev_q + 14'h1;
               end else begin
                  pos_q <= pos_plus;
               end
            end else if (pos_q < {16'h0, step_sz}) begin
               pos_q <= pos_q + rev_len - {16'h0, step_sz};
               rev_q <= rev_q - 14'h1;
            end else begin
               pos_q <= pos_q - {16'h0, step_sz};
            end
         end
      end
   end

   // ==========================================================
   // Sticky events; a set in the same cycle as a clear wins
   wire [3:0] ev_set = {trip_event, alarm, frame_done, mrk_accept};
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_stat_q <= 4'h0;
         fault_class_q <= 4'h0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | ev_set;
         if (trip_event) begin
            fault_class_q <= `P2PFI_FAULT_CLASS_COMMS;
         end
      end
   end

   // ==========================================================
   // Outputs and read port; wire break detection is not offered
   // on incremental types, so error bit 0 never reaches a trip
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 32'h0;
         fb_position_o <= 32'h0;
         fb_valid_o <= 1'b0;
         trip_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         fb_valid_o <= (fb_sel_q == `P2PFI_FB_SEL_P2);
         fb_position_o <= (fb_sel_q == `P2PFI_FB_SEL_P2) ? combined : 32'h0;
         trip_o <= irq_stat_q[`P2PFI_IRQ_TRIP_BIT] && !incr_mode;
         irq_o <= |(irq_stat_q & irq_mask_q);
         rdata_o <= 32'h0;
         if (rd_i) begin
            if (addr_i == `P2PFI_DEVICE_TYPE_ADDR) begin
               rdata_o <= {27'h0, dev_type_q};
            end else if (addr_i == `P2PFI_FB_SELECT_ADDR) begin
               rdata_o <= {30'h0, fb_sel_q};
            end else if (addr_i == `P2PFI_LINES_PER_REV_ADDR) begin
               rdata_o <= {18'h0, lpr_q};
            end else if (addr_i == `P2PFI_MARKER_CTRL_ADDR) begin
               rdata_o <= {28'h0, mrk_ctrl_q};
            end else if (addr_i == `P2PFI_ERROR_CTRL_ADDR) begin
               rdata_o <= {28'h0, err_ctrl_q};
            end else if (addr_i == `P2PFI_BAUD_ADDR) begin
               rdata_o <= {28'h0, baud_q};
            end else if (addr_i == `P2PFI_SERIAL_CFG_ADDR) begin
               rdata_o <= {30'h0, ser_cfg_q};
            end else if (addr_i == `P2PFI_TURNS_BITS_ADDR) begin
               rdata_o <= {27'h0, turns_bits};
            end else if (addr_i == `P2PFI_COMMS_BITS_ADDR) begin
               rdata_o <= {26'h0, comms_bits};
            end else if (addr_i == `P2PFI_POSITION_ADDR) begin
               rdata_o <= combined;
            end else if (addr_i == `P2PFI_MARKER_CAPT_ADDR) begin
               rdata_o <= capture_q;
            end else if (addr_i == `P2PFI_IRQ_STATUS_ADDR) begin
               rdata_o <= {28'h0, irq_stat_q};
            end else if (addr_i == `P2PFI_IRQ_MASK_ADDR) begin
               rdata_o <= {28'h0, irq_mask_q};
            end else if (addr_i == `P2PFI_FAULT_ADDR) begin
               rdata_o <= {28'h0, fault_class_q};
            end
         end
      end
   end

endmodule // p2pfi_top

/* File: test/p2pfi_sva.sv */
/* Checker of the feedback interface top ports.
   Assumes one-cycle register strobes; bound below. */
`timescale 1ns/100ps
`include "p2pfi_regs.vh"
module p2pfi_sva (
   input wire clk_i,
   input wire resetn_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire sdata_oe_o,
   input wire sclk_o,
   input wire [31:0] fb_position_o,
   input wire fb_valid_o,
   input wire trip_o,
   input wire irq_o
);
   logic [4:0] type_q;
   logic [1:0] sel_q;
   logic [3:0] err_q;
   logic [8:0] cnt_q;
   // Shadow of the settings the properties depend on
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         type_q <= `P2PFI_DEVICE_TYPE_RST;
         sel_q <= 2'h0;
         err_q <= 4'h0;
         cnt_q <= 9'h000;
      end else begin
         if (cnt_q != 9'h1ff) cnt_q <= cnt_q + 9'h001;
         if (wr_i && addr_i == `P2PFI_DEVICE_TYPE_ADDR) type_q <= wdata_i[4:0];
         if (wr_i && addr_i == `P2PFI_FB_SELECT_ADDR) sel_q <= wdata_i[1:0];
         if (wr_i && addr_i == `P2PFI_ERROR_CTRL_ADDR) err_q <= wdata_i[3:0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Slowest rate keeps the clock low for 50 cycles
   sequence s_sclk_back;
      ##[1:50] sclk_o;
   endsequence
   a_fb_select: assert property (fb_valid_o == ($past(sel_q) == `P2PFI_FB_SEL_P2))
      else $error("feedback valid does not follow selector");
   a_fb_zero: assert property (!fb_valid_o |-> fb_position_o == 32'h0)
      else $error("feedback position leaks while unselected");
   a_trip_type: assert property (trip_o |-> $past(type_q) inside {5'h04, 5'h05, 5'h06})
      else $error("trip on an incremental type");
   a_trip_hold: assert property (err_q[3] && !trip_o |=> !trip_o)
      else $error("trip raised while suppressed");
   a_oe_bidir: assert property ($rose(sdata_oe_o) |-> type_q == `P2PFI_TYPE_BIDIR)
      else $error("data driven outside bidirectional type");
   a_sclk_low: assert property ($fell(sclk_o) |-> s_sclk_back)
      else $error("serial clock low too long");
   a_gap_first: assert property (cnt_q < 9'h122 |-> sclk_o)
      else $error("frame started inside reset gap");
   a_irq_masked: assert property (wr_i && addr_i == `P2PFI_IRQ_MASK_ADDR &&
      wdata_i[3:0] == 4'h0 |-> ##2 !irq_o)
      else $error("interrupt high with all masked");
endmodule // p2pfi_sva
bind p2pfi_top p2pfi_sva u_sva (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .sdata_oe_o(sdata_oe_o), .sclk_o(sclk_o),
   .fb_position_o(fb_position_o), .fb_valid_o(fb_valid_o), .trip_o(trip_o), .irq_o(irq_o));

/* File: test/p2pfi_enc_model.sv */
/* Behavioural absolute serial encoder.
   Assumes the reader idles its clock high between frames. */
`timescale 1ns/100ps
module p2pfi_enc_model #(
   parameter int NBITS = 26
) (
   input wire clk_i,
   input wire sclk_i,
   input wire present_i,
   input wire [31:0] word_i,
   output logic sdata_o
);
   int idx = 0;
   int idle = 0;
   logic bit_q = 1'b1;
   // Line idles high as ready; a missing encoder leaves it low
   assign sdata_o = present_i ? bit_q : 1'b0;
   // Long high clock ends the frame, as the encoder monoflop does
   always @(posedge clk_i) begin
      idle = sclk_i ? idle + 1 : 0;
      if (idle > 150) begin
         idx = 0;
         bit_q = 1'b1;
      end
   end
   // One bit per falling clock, turns first, most significant first
   always @(negedge sclk_i) begin
      bit_q = (idx < NBITS) ? word_i[NBITS - 1 - idx] : 1'b0;
      idx = idx + 1;
   end
endmodule // p2pfi_enc_model

/* File: test/p2pfi_top_test.sv */
/* Self-checking bench of the feedback interface.
   Assumes the checker and encoder model are compiled first. */
`timescale 1ns/100ps
`include "p2pfi_regs.vh"
module p2pfi_top_test;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0, rd = 1'b0, a = 1'b0, b = 1'b0, z = 1'b0, present = 1'b1;
   logic [31:0] word = 32'h0, rdv, rdata, fbp;
   logic sd_out, sd_oe, sclk, fbv, trip, irq, enc_sd;
   logic [1:0] ph = 2'h0;
   logic [7:0] cmd;
   logic [24:0] v = 25'h1234567;
   // Rows: rate code, then expected clock low cycles
   logic [11:0] rows [9] = '{12'h032, 12'h119, 12'h210, 12'h30c, 12'h40a, 12'h505,
      12'h603, 12'h702, 12'h801};
   int failures = 0, tests_run = 0, k, n;
   wire sdata = sd_oe ? sd_out : enc_sd;
   always #50 clk = ~clk;
   p2pfi_top dut (.clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .enc_a_i(a), .enc_b_i(b), .enc_z_i(z), .sdata_i(sdata),
      .sdata_o(sd_out), .sdata_oe_o(sd_oe), .sclk_o(sclk), .fb_position_o(fbp),
      .fb_valid_o(fbv), .trip_o(trip), .irq_o(irq));
   p2pfi_enc_model enc (.clk_i(clk), .sclk_i(sclk), .present_i(present), .word_i(word),
      .sdata_o(enc_sd));
   // ==========================================================
   // Helpers
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task wr_reg(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] ad);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rdv = rdata;
   endtask
   task rst;
      @(posedge clk);
      resetn <= 1'b0;
      a <= 1'b0;
      b <= 1'b0;
      ph = 2'h0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
   endtask
   task inc(input logic [31:0] t);
      rst;
      wr_reg(`P2PFI_DEVICE_TYPE_ADDR, t);
      wr_reg(`P2PFI_FB_SELECT_ADDR, 32'h1);
      wr_reg(`P2PFI_LINES_PER_REV_ADDR, 32'h2);
   endtask
   // Quadrature steps counting up (B leads A); two extra falling edges let the output settle
   task step(input int m);
      repeat (m) begin
         @(posedge clk);
         ph = ph + 2'h1;
         a <= ph[1];
         b <= ph[0] ^ ph[1];
         repeat (3) @(posedge clk);
      end
      repeat (2) @(negedge clk);
   endtask
   task zp(input int w);
      @(posedge clk);
      z <= 1'b1;
      repeat (w) @(posedge clk);
      z <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Whole run needs about 12000 cycles; five times that is a hang
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      stop_test;
   end
   // ==========================================================
   // Scenarios
   initial begin
      for (k = 0; k < 9; k++) begin
         rst;
         wr_reg(`P2PFI_DEVICE_TYPE_ADDR, k % 2 ? 32'h6 : 32'h5);
         wr_reg(`P2PFI_BAUD_ADDR, {28'h0, rows[k][11:8]});
         for (n = 0; sclk && n < 1000; n++) @(negedge clk);
         for (n = 0; !sclk && n < 200; n++) @(negedge clk);
         chk("sclk low", {24'h0, rows[k][7:0]}, n);
      end
      // Gray then binary frame with the alarm bit last
      for (k = 0; k < 2; k++) begin
         rst;
         word = {6'h0, (k ? v : v ^ (v >> 1)), 1'b1};
         wr_reg(`P2PFI_DEVICE_TYPE_ADDR, 32'h5);
         wr_reg(`P2PFI_BAUD_ADDR, 32'h0);
         wr_reg(`P2PFI_FB_SELECT_ADDR, 32'h1);
         wr_reg(`P2PFI_SERIAL_CFG_ADDR, k ? 32'h3 : 32'h1);
         wr_reg(`P2PFI_ERROR_CTRL_ADDR, 32'h4);
         wr_reg(`P2PFI_IRQ_MASK_ADDR, 32'h2);
         for (n = 0; !irq && n < 4000; n++) @(negedge clk);
         chk("frame irq", 32'h1, {31'h0, irq});
         chk("ssi position", {2'h0, v[24:13], 5'h0, v[12:0]}, fbp);
         rd_reg(`P2PFI_IRQ_STATUS_ADDR);
         chk("ssi status", 32'h6, rdv);
         wr_reg(`P2PFI_IRQ_STATUS_ADDR, 32'h6);
         wr_reg(`P2PFI_IRQ_MASK_ADDR, 32'h0);
      end
      rst;
      present <= 1'b0;
      wr_reg(`P2PFI_DEVICE_TYPE_ADDR, 32'h5);
      for (n = 0; !trip && n < 1000; n++) @(negedge clk);
      chk("trip", 32'h1, {31'h0, trip});
      rd_reg(`P2PFI_FAULT_ADDR);
      chk("fault class", 32'h4, rdv);
      rst;
      wr_reg(`P2PFI_ERROR_CTRL_ADDR, 32'h8);
      wr_reg(`P2PFI_DEVICE_TYPE_ADDR, 32'h5);
      repeat (1000) @(negedge clk);
      chk("trip suppressed", 32'h0, {31'h0, trip});
      present <= 1'b1;
      // Bidirectional type: counts from auto setup, command out, then manual counts
      rst;
      wr_reg(`P2PFI_DEVICE_TYPE_ADDR, 32'h4);
      wr_reg(`P2PFI_TURNS_BITS_ADDR, 32'h5);
      rd_reg(`P2PFI_TURNS_BITS_ADDR);
      chk("auto turns", 32'hc, rdv);
      for (k = 0; k < 8; k++) begin
         @(negedge sclk);
         @(negedge clk);
         cmd = {cmd[6:0], sd_out};
      end
      chk("command", 32'h107, {23'h0, sd_oe, cmd});
      wr_reg(`P2PFI_SERIAL_CFG_ADDR, 32'h0);
      rd_reg(`P2PFI_TURNS_BITS_ADDR);
      chk("manual turns", 32'h5, rdv);
      // Incremental counting and marker modes
      inc(32'h1);
      step(9);
      chk("quadrature", {14'h1, 18'h1}, fbp);
      // Frequency/direction, then forward/reverse: four A pulses make one turn
      for (k = 2; k < 4; k++) begin
         inc(k);
         repeat (4) begin
            @(posedge clk);
            a <= 1'b1;
            repeat (4) @(posedge clk);
            a <= 1'b0;
            repeat (4) @(posedge clk);
         end
         @(negedge clk);
         chk("freq dir", {14'h1, 18'h0}, fbp);
      end
      inc(32'h1);
      step(3);
      wr_reg(`P2PFI_MARKER_CTRL_ADDR, 32'h2);
      zp(4);
      chk("marker zero", 32'h0, fbp);
      wr_reg(`P2PFI_MARKER_CTRL_ADDR, 32'h3);
      step(2);
      zp(4);
      chk("marker once", 32'h2, fbp);
      wr_reg(`P2PFI_IRQ_STATUS_ADDR, 32'h1);
      wr_reg(`P2PFI_MARKER_CTRL_ADDR, 32'ha);
      zp(50);
      chk("marker short", 32'h2, fbp);
      zp(120);
      chk("marker long", 32'h0, fbp);
      wr_reg(`P2PFI_MARKER_CTRL_ADDR, 32'h6);
      step(1);
      zp(4);
      chk("marker keep", 32'h1, fbp);
      rd_reg(`P2PFI_MARKER_CAPT_ADDR);
      chk("marker capture", 32'h1, rdv);
      stop_test;
   end
endmodule // p2pfi_top_test
